// file: vec_gate_pkg.sv
// Constants and types for the wide-vector feature gate
package vec_gate_pkg;
  // Register port offsets
  localparam logic [7:0] ADDR_LEAF7_EBX = 8'h00;
  localparam logic [7:0] ADDR_LEAF1_ECX = 8'h04;
  localparam logic [7:0] ADDR_STATE_EN = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Feature query bit positions
  localparam int BIT_BASE = 16;
  localparam int BIT_DQ = 17;
  localparam int BIT_PF = 26;
  localparam int BIT_ER = 27;
  localparam int BIT_CD = 28;
  localparam int BIT_BW = 30;
  localparam int BIT_OS_EN = 27;
  // Extended-state enable register fields
  localparam int SE_W = 8;
  localparam int SE_MASK_LO = 5;
  localparam int SE_MASK_HI = 7;
  localparam int SE_VEC_LO = 1;
  localparam int SE_VEC_HI = 2;
  localparam logic [2:0] SE_MASK_REQ = 3'h7;
  localparam logic [1:0] SE_VEC_REQ = 2'h3;
  localparam logic [1:0] SE_VEC_OFF = 2'h0;
  localparam logic [SE_W-1:0] SE_RESET = 8'h01;
  // Control and status bits
  localparam int CTRL_OS_EN = 0;
  localparam int CTRL_PRIV = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_REFUSED = 0;
  localparam int ST_USABLE_LO = 8;
  // Instruction groups
  localparam int NUM_GROUPS = 6;
  typedef enum logic [2:0] {
    GRP_BASE = 3'h0, GRP_DQ = 3'h1, GRP_PF = 3'h2,
    GRP_ER = 3'h3, GRP_CD = 3'h4, GRP_BW = 3'h5
  } grp_t;
  // Operand register class
  typedef enum logic [1:0] {
    CLS_VEC = 2'h0, CLS_LEGACY_MM = 2'h1, CLS_STACK_FP = 2'h2,
    CLS_GPR = 2'h3
  } opnd_class_t;
  // Prefix payload field positions
  localparam int P0_R = 7;
  localparam int P0_RP = 4;
  localparam int P1_W = 7;
  localparam int P1_V_LO = 3;
  localparam int P1_V_HI = 6;
  localparam int P2_Z = 7;
  localparam int P2_LL_LO = 5;
  localparam int P2_LL_HI = 6;
  localparam int P2_BCST = 4;
  localparam int P2_VP = 3;
  localparam int P2_AAA_HI = 2;
  // Vector length codes and displacement scale shifts
  localparam logic [1:0] LL_128 = 2'h0;
  localparam logic [1:0] LL_256 = 2'h1;
  localparam logic [1:0] LL_512 = 2'h2;
  localparam logic [2:0] SH_128 = 3'h4;
  localparam logic [2:0] SH_256 = 3'h5;
  localparam logic [2:0] SH_512 = 3'h6;
  localparam logic [2:0] SH_ELEM32 = 3'h2;
  localparam logic [2:0] SH_ELEM64 = 3'h3;
  // Implied operand prefixes and escape maps
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_66 = 8'h66;
  localparam logic [7:0] PFX_F3 = 8'hf3;
  localparam logic [7:0] PFX_F2 = 8'hf2;
  localparam logic [15:0] ESC_NONE = 16'h0000;
  localparam logic [15:0] ESC_0F = 16'h000f;
  localparam logic [15:0] ESC_0F38 = 16'h0f38;
  localparam logic [15:0] ESC_0F3A = 16'h0f3a;

  typedef struct packed {
    logic valid;
    logic prefixed;
    logic [7:0] p0;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [2:0] modrm_reg;
    logic [7:0] disp8;
    logic mode64;
    opnd_class_t opnd_class;
    grp_t group;
    logic is_mem;
    logic is_mask_op;
    logic is_t1w_prefetch;
    logic is_vec256;
  } dec_req_t;

  typedef struct packed {
    logic accept;
    logic ud_fault;
    logic [4:0] reg_idx;
    logic [4:0] src_idx;
    logic [2:0] mask_sel;
    logic zeroing;
    logic bcst;
    logic [1:0] vlen;
    logic [7:0] imp_prefix;
    logic [15:0] escape;
    logic [31:0] disp;
    logic mask_only;
  } dec_resp_t;
endpackage

// file: group_gate.sv
// Usable term for one instruction group
`timescale 1ns/1ps
`default_nettype none
module group_gate #(
  parameter bit NEED_BASE = 1'b1
) (
  input wire logic group_flag, // Group present
  input wire logic base_flag, // Base group present
  input wire logic os_en, // OS state management on
  input wire logic state_ok, // Required state enables set
  output logic usable // Group may execute
);
  assign usable = group_flag & (base_flag | ~NEED_BASE) & os_en & state_ok; // RL22
endmodule
`default_nettype wire

// file: wide_vector_feature_gate.sv
// Wide-vector feature enumeration and prefix qualification
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Leaf 7 EBX bit 16 reports the base vector group.
// RL2 - Leaf 1 ECX bit 27 reports OS state management enabled.
// RL3 - State enable bits 7 to 5 must all be set.
// RL4 - State enable bits 2 and 1 must both be set.
// RL5 - Leaf 7 EBX bit 27 reports exponential/reciprocal group.
// RL6 - Leaf 7 EBX bit 26 reports gather/scatter prefetch group.
// RL7 - Bits 28, 17, 30 report conflict, dword/qword, byte/word groups.
// RL8 - Program checks OS flag, state fields, base and group flag first.
// RL9 - OS flag set implies save, restore and state register reads work.
// RL10 - State enable register writes only at privileged level.
// RL11 - Half-precision support forces the byte/word group present.
// RL12 - Prefix accepted for vector registers, never legacy or stack regs.
// RL13 - Prefix extension fields address 32 vector registers in 64-bit.
// RL14 - Prefix selects mask registers 1 to 7 for masking.
// RL15 - Prefix fields imply operand prefix and escape bytes.
// RL16 - Two-bit length field sets 128, 256 or 512 bit length.
// RL17 - Broadcast attribute taken for memory source operands.
// RL18 - Mask operations touch only mask or general registers.
// RL19 - Compressed displacement scaled from the short form.
// RL20 - Write-intent prefetch needs no OS state enables.
// RL21 - Plain 256-bit ops fault when state bits 2 and 1 clear.
// RL22 - Group usable is group, base, OS flag and state enables ANDed.
module wide_vector_feature_gate #(
  parameter bit HAS_BASE = 1'b1,
  parameter bit HAS_DQ = 1'b1,
  parameter bit HAS_PF = 1'b0,
  parameter bit HAS_ER = 1'b0,
  parameter bit HAS_CD = 1'b1,
  parameter bit HAS_BW = 1'b1,
  parameter bit HAS_HALF_FP = 1'b0
) (
  input wire logic clk, // 25 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input wire vec_gate_pkg::dec_req_t req, // Decode request
  output vec_gate_pkg::dec_resp_t resp, // Decode answer
  output logic resp_valid, // Answer valid pulse
  output logic [vec_gate_pkg::NUM_GROUPS-1:0] usable // Group usable
);
  logic [vec_gate_pkg::SE_W-1:0] state_en_q;
  logic [1:0] ctrl_q;
  logic refused_q;
  logic refused_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  vec_gate_pkg::dec_resp_t resp_q;
  vec_gate_pkg::dec_resp_t resp_d;
  logic resp_valid_q;
  logic [vec_gate_pkg::NUM_GROUPS-1:0] usable_q;

  // Feature query words
  logic [31:0] leaf7_ebx;
  logic [31:0] leaf1_ecx;
  logic [vec_gate_pkg::NUM_GROUPS-1:0] grp_flag;
  logic [vec_gate_pkg::NUM_GROUPS-1:0] grp_usable;
  wire bw_present = HAS_BW | HAS_HALF_FP; // RL11
  wire os_en = ctrl_q[vec_gate_pkg::CTRL_OS_EN];
  wire priv = ctrl_q[vec_gate_pkg::CTRL_PRIV];

  always_comb begin
    leaf7_ebx = '0;
    leaf7_ebx[vec_gate_pkg::BIT_BASE] = HAS_BASE; // RL1
    leaf7_ebx[vec_gate_pkg::BIT_ER] = HAS_ER; // RL5
    leaf7_ebx[vec_gate_pkg::BIT_PF] = HAS_PF; // RL6
    leaf7_ebx[vec_gate_pkg::BIT_CD] = HAS_CD; // RL7
    leaf7_ebx[vec_gate_pkg::BIT_DQ] = HAS_DQ; // RL7
    leaf7_ebx[vec_gate_pkg::BIT_BW] = bw_present; // RL7
  end

  always_comb begin
    leaf1_ecx = '0;
    leaf1_ecx[vec_gate_pkg::BIT_OS_EN] = os_en; // RL2
  end

  assign grp_flag[vec_gate_pkg::GRP_BASE] =
    leaf7_ebx[vec_gate_pkg::BIT_BASE];
  assign grp_flag[vec_gate_pkg::GRP_DQ] = leaf7_ebx[vec_gate_pkg::BIT_DQ];
  assign grp_flag[vec_gate_pkg::GRP_PF] = leaf7_ebx[vec_gate_pkg::BIT_PF];
  assign grp_flag[vec_gate_pkg::GRP_ER] = leaf7_ebx[vec_gate_pkg::BIT_ER];
  assign grp_flag[vec_gate_pkg::GRP_CD] = leaf7_ebx[vec_gate_pkg::BIT_CD];
  assign grp_flag[vec_gate_pkg::GRP_BW] = leaf7_ebx[vec_gate_pkg::BIT_BW];

  // State enable qualification
  wire [2:0] se_mask =
    state_en_q[vec_gate_pkg::SE_MASK_HI:vec_gate_pkg::SE_MASK_LO];
  wire [1:0] se_vec =
    state_en_q[vec_gate_pkg::SE_VEC_HI:vec_gate_pkg::SE_VEC_LO];
  wire mask_state_ok = (se_mask == vec_gate_pkg::SE_MASK_REQ); // RL3
  wire vec_state_ok = (se_vec == vec_gate_pkg::SE_VEC_REQ); // RL4
  wire vec_state_off = (se_vec == vec_gate_pkg::SE_VEC_OFF);
  wire state_ok = mask_state_ok & vec_state_ok;

  for (genvar g = 0; g < vec_gate_pkg::NUM_GROUPS; g++) begin : gate
    group_gate #(
      .NEED_BASE(1'b1)
    ) u_gate (
      .group_flag(grp_flag[g]),
      .base_flag(grp_flag[vec_gate_pkg::GRP_BASE]),
      .os_en(os_en),
      .state_ok(state_ok),
      .usable(grp_usable[g])
    );
  end

  // Register port decode
  wire sel_leaf7 = (addr == vec_gate_pkg::ADDR_LEAF7_EBX);
  wire sel_leaf1 = (addr == vec_gate_pkg::ADDR_LEAF1_ECX);
  wire sel_se = (addr == vec_gate_pkg::ADDR_STATE_EN);
  wire sel_ctrl = (addr == vec_gate_pkg::ADDR_CTRL);
  wire sel_status = (addr == vec_gate_pkg::ADDR_STATUS);
  wire se_write_ok = wr & sel_se & priv; // RL10
  wire se_write_bad = wr & sel_se & ~priv; // RL10
  wire refused_clr = wr & sel_status & wdata[vec_gate_pkg::ST_REFUSED];
  // Reads of the state enable register need OS management on
  wire [31:0] se_read = os_en ? {24'h000000, state_en_q} : '0; // RL9
  wire [31:0] ctrl_read = {30'h00000000, ctrl_q};
  wire [31:0] status_read =
    {18'h00000, usable_q, 7'h00, refused_q};

  // New refusal wins over a clear in the same cycle
  assign refused_d = se_write_bad | (refused_q & ~refused_clr);

  always_comb begin
    rdata_d = '0;
    if (rd) begin
      if (sel_leaf7) begin
        rdata_d = leaf7_ebx;
      end else if (sel_leaf1) begin
        rdata_d = leaf1_ecx;
      end else if (sel_se) begin
        rdata_d = se_read;
      end else if (sel_ctrl) begin
        rdata_d = ctrl_read;
      end else if (sel_status) begin
        rdata_d = status_read;
      end
    end
  end

  // Prefix field extraction
  wire [1:0] mm = req.p0[1:0];
  wire [1:0] pp = req.p1[1:0];
  wire [3:0] vvvv = req.p1[vec_gate_pkg::P1_V_HI:vec_gate_pkg::P1_V_LO];
  wire [1:0] ll = req.p2[vec_gate_pkg::P2_LL_HI:vec_gate_pkg::P2_LL_LO];
  wire [2:0] aaa = req.p2[vec_gate_pkg::P2_AAA_HI:0];
  wire w_bit = req.p1[vec_gate_pkg::P1_W];
  wire r_ext = ~req.p0[vec_gate_pkg::P0_R];
  wire rp_ext = ~req.p0[vec_gate_pkg::P0_RP];
  wire vp_ext = ~req.p2[vec_gate_pkg::P2_VP];

  wire legacy_cls = (req.opnd_class == vec_gate_pkg::CLS_LEGACY_MM) |
                    (req.opnd_class == vec_gate_pkg::CLS_STACK_FP);
  wire class_ok = ~legacy_cls; // RL12
  wire map_ok = (mm != 2'h0);
  wire vlen_ok = (ll == vec_gate_pkg::LL_128) |
                 (ll == vec_gate_pkg::LL_256) |
                 (ll == vec_gate_pkg::LL_512); // RL16
  // Unused group codes are refused except for write-intent prefetch
  wire grp_known = (req.group <= vec_gate_pkg::GRP_BW);
  wire grp_ok = grp_known & grp_usable[req.group]; // RL22
  // Write-intent prefetch bypasses the state enable checks
  wire gate_ok = req.is_t1w_prefetch | grp_ok; // RL20
  wire pfx_accept = class_ok & map_ok & vlen_ok & gate_ok;
  wire plain_fault = req.is_vec256 & vec_state_off; // RL21
  wire accept = req.prefixed ? pfx_accept : ~plain_fault;

  // Register indices, 32 vector registers only in 64-bit mode
  wire [4:0] reg_vec = req.mode64 ? {rp_ext, r_ext, req.modrm_reg} :
                                    {2'b00, req.modrm_reg}; // RL13
  wire [4:0] src_vec = req.mode64 ? {vp_ext, ~vvvv} :
                                    {2'b00, ~vvvv[2:0]}; // RL13
  // Mask operations address one of 8 mask registers
  wire [4:0] reg_idx = req.is_mask_op ? {2'b00, req.modrm_reg} :
                                        reg_vec; // RL18
  wire [4:0] src_idx = req.is_mask_op ? {2'b00, ~vvvv[2:0]} :
                                        src_vec; // RL18

  wire [7:0] imp_prefix = (pp == 2'h1) ? vec_gate_pkg::PFX_66 :
                          (pp == 2'h2) ? vec_gate_pkg::PFX_F3 :
                          (pp == 2'h3) ? vec_gate_pkg::PFX_F2 :
                                         vec_gate_pkg::PFX_NONE; // RL15
  wire [15:0] escape = (mm == 2'h1) ? vec_gate_pkg::ESC_0F :
                       (mm == 2'h2) ? vec_gate_pkg::ESC_0F38 :
                       (mm == 2'h3) ? vec_gate_pkg::ESC_0F3A :
                                      vec_gate_pkg::ESC_NONE; // RL15

  // Broadcast only has meaning with a memory source
  wire bcst = req.p2[vec_gate_pkg::P2_BCST] & req.is_mem; // RL17

  // Compressed displacement scale
  wire [2:0] vl_shift = (ll == vec_gate_pkg::LL_512) ? vec_gate_pkg::SH_512 :
                        (ll == vec_gate_pkg::LL_256) ? vec_gate_pkg::SH_256 :
                                                       vec_gate_pkg::SH_128;
  wire [2:0] el_shift = w_bit ? vec_gate_pkg::SH_ELEM64 :
                                vec_gate_pkg::SH_ELEM32;
  wire [2:0] disp_shift = bcst ? el_shift : vl_shift; // RL19
  wire [31:0] disp_ext = {{24{req.disp8[7]}}, req.disp8};
  wire [31:0] disp_scaled = disp_ext << disp_shift; // RL19

  always_comb begin
    resp_d = '0;
    resp_d.accept = accept;
    resp_d.ud_fault = ~accept;
    if (req.prefixed) begin
      resp_d.reg_idx = reg_idx;
      resp_d.src_idx = src_idx;
      resp_d.mask_sel = aaa; // RL14
      resp_d.zeroing = req.p2[vec_gate_pkg::P2_Z]; // RL14
      resp_d.bcst = bcst;
      resp_d.vlen = ll; // RL16
      resp_d.imp_prefix = imp_prefix;
      resp_d.escape = escape;
      resp_d.disp = disp_scaled;
      resp_d.mask_only = req.is_mask_op; // RL18
    end else begin
      resp_d.reg_idx = {2'b00, req.modrm_reg};
      resp_d.disp = disp_ext;
    end
  end

  // Software-visible state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_en_q <= vec_gate_pkg::SE_RESET;
      ctrl_q <= vec_gate_pkg::CTRL_RESET;
      refused_q <= 1'b0;
    end else begin
      if (se_write_ok) begin
        state_en_q <= wdata[vec_gate_pkg::SE_W-1:0]; // RL10
      end
      if (wr && sel_ctrl) begin
        ctrl_q <= wdata[1:0];
      end
      refused_q <= refused_d;
    end
  end

  // Registered answers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
      resp_q <= '0;
      resp_valid_q <= 1'b0;
      usable_q <= '0;
    end else begin
      rdata_q <= rdata_d;
      resp_valid_q <= req.valid;
      if (req.valid) begin
        resp_q <= resp_d;
      end
      usable_q <= grp_usable; // RL22
    end
  end

  assign rdata = rdata_q;
  assign resp = resp_q;
  assign resp_valid = resp_valid_q;
  assign usable = usable_q;
endmodule
`default_nettype wire

// file: wide_vector_feature_gate_props.sv
// Port assertions for the wide-vector feature gate
`timescale 1ns/1ps
`default_nettype none
module wide_vector_feature_gate_props (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [7:0] addr, // Register address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire vec_gate_pkg::dec_req_t req, // Decode request
  input wire vec_gate_pkg::dec_resp_t resp, // Decode answer
  input wire logic resp_valid, // Answer valid
  input wire logic [vec_gate_pkg::NUM_GROUPS-1:0] usable // Group usable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  vec_gate_pkg::dec_req_t req_q;
  wire logic pv = req.valid && req.prefixed;
  // Request of the previous edge
  always_ff @(posedge clk) req_q <= req;
  logic [1:0] ctrl_s;
  logic [vec_gate_pkg::SE_W-1:0] se_s;
  // Shadow of control and state enable, from the register port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_s <= vec_gate_pkg::CTRL_RESET;
      se_s <= vec_gate_pkg::SE_RESET;
    end else begin
      if (wr && addr == vec_gate_pkg::ADDR_CTRL) begin
        ctrl_s <= wdata[1:0];
      end
      if (wr && addr == vec_gate_pkg::ADDR_STATE_EN &&
          ctrl_s[vec_gate_pkg::CTRL_PRIV]) begin
        se_s <= wdata[vec_gate_pkg::SE_W-1:0];
      end
    end
  end
  a_plain_fault: assert property (req.valid && !req.prefixed &&
    req.is_vec256 && se_s[2:1] == 2'h0 |=> resp.ud_fault)
    else $error("plain 256-bit op not refused");
  a_se_read_gate: assert property (rd && addr ==
    vec_gate_pkg::ADDR_STATE_EN && !ctrl_s[vec_gate_pkg::CTRL_OS_EN] |=>
    rdata == 32'h0) else $error("state enable read while off");
  a_answer_pulse: assert property (req.valid |=> resp_valid)
    else $error("answer missing");
  a_idle_quiet: assert property (!req.valid |=> !resp_valid && $stable(resp))
    else $error("answer without request");
  a_legacy_refused: assert property (pv && (req.opnd_class ==
    vec_gate_pkg::CLS_LEGACY_MM || req.opnd_class ==
    vec_gate_pkg::CLS_STACK_FP) |=> !resp.accept) else $error("legacy taken");
  a_fault_flag: assert property (resp_valid |->
    resp.ud_fault == !resp.accept) else $error("fault flag wrong");
  a_mask_vlen: assert property (pv |=>
    resp.mask_sel == req_q.p2[2:0] && resp.vlen == req_q.p2[6:5])
    else $error("mask or length wrong");
  a_escape_map: assert property (pv && req.p0[1:0] == 2'h2 |=>
    resp.escape == vec_gate_pkg::ESC_0F38) else $error("escape wrong");
  a_bcst_memory: assert property (req.valid && !req.is_mem |=> !resp.bcst)
    else $error("broadcast without memory");
  a_reg_extend: assert property (pv && req.mode64 && !req.is_mask_op |=>
    resp.reg_idx == {~req_q.p0[4], ~req_q.p0[7], req_q.modrm_reg})
    else $error("register index wrong");
  a_mask_regs: assert property (pv && req.is_mask_op |=>
    resp.reg_idx[4:3] == 2'h0 && resp.src_idx[4:3] == 2'h0)
    else $error("mask op index wrong");
  a_prefetch_free: assert property (pv && req.is_t1w_prefetch &&
    req.opnd_class == vec_gate_pkg::CLS_VEC && req.p0[1:0] != 2'h0 &&
    req.p2[6:5] != 2'h3 |=> resp.accept) else $error("prefetch refused");
  a_usable_base: assert property (usable != '0 |-> usable[0])
    else $error("group usable without base");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read");
  c_accept: cover property (resp_valid && resp.accept);
  c_refuse: cover property (resp_valid && resp.ud_fault);
  c_usable: cover property (usable[5]);
endmodule
bind wide_vector_feature_gate wide_vector_feature_gate_props i_props (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .req(req), .resp(resp), .resp_valid(resp_valid),
  .usable(usable));
`default_nettype wire

// file: wide_vector_feature_gate_bench.sv
// Self-checking bench for the wide-vector feature gate
`timescale 1ns/1ps
`default_nettype none
module wide_vector_feature_gate_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  vec_gate_pkg::dec_req_t req = '0;
  vec_gate_pkg::dec_resp_t resp;
  logic resp_valid;
  logic [5:0] usable;
  logic [31:0] rng = 32'h0001_7af6;
  logic [7:0] se = 8'h01;
  logic [7:0] ses [7] = '{8'h67, 8'ha7, 8'hc7, 8'he5, 8'he3, 8'hff, 8'he7};
  logic [7:0] cfgs [3] = '{8'he7, 8'h07, 8'h01};
  vec_gate_pkg::dec_req_t hr;
  int fail_count = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  wide_vector_feature_gate i_dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .req(req), .resp(resp),
    .resp_valid(resp_valid), .usable(usable));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [5:0] exp_us(logic [7:0] v, logic os);
    return (os && v[7:5] == 3'h7 && v[2:1] == 2'h3) ? 6'h33 : 6'h00;
  endfunction
  function automatic vec_gate_pkg::dec_resp_t exp_resp(
    vec_gate_pkg::dec_req_t r, logic [7:0] v);
    vec_gate_pkg::dec_resp_t e;
    logic [3:0] n;
    logic [1:0] ll;
    logic [2:0] sh;
    logic [5:0] us;
    e = '0;
    us = exp_us(v, 1'b1);
    n = ~r.p1[6:3];
    ll = r.p2[6:5];
    e.reg_idx = {2'h0, r.modrm_reg};
    e.disp = {{24{r.disp8[7]}}, r.disp8};
    e.accept = !(r.is_vec256 && v[2:1] == 2'h0);
    if (r.prefixed) begin
      e.accept = r.opnd_class != vec_gate_pkg::CLS_LEGACY_MM &&
        r.opnd_class != vec_gate_pkg::CLS_STACK_FP && r.p0[1:0] != 2'h0 &&
        ll != 2'h3 && (r.is_t1w_prefetch || us[r.group]);
      e.src_idx = {2'h0, n[2:0]};
      if (r.mode64 && !r.is_mask_op) begin
        e.reg_idx = {~r.p0[4], ~r.p0[7], r.modrm_reg};
        e.src_idx = {~r.p2[3], n};
      end
      e.mask_sel = r.p2[2:0];
      e.zeroing = r.p2[7];
      e.vlen = ll;
      e.mask_only = r.is_mask_op;
      e.bcst = r.p2[4] & r.is_mem;
      sh = e.bcst ? (r.p1[7] ? 3'h3 : 3'h2) : 3'h4 + 3'(ll);
      e.disp = e.disp << sh;
      e.imp_prefix = r.p1[1:0] == 2'h1 ? 8'h66 : r.p1[1:0] == 2'h2 ? 8'hf3 :
        r.p1[1:0] == 2'h3 ? 8'hf2 : 8'h00;
      e.escape = r.p0[1:0] == 2'h1 ? 16'h000f : r.p0[1:0] == 2'h2 ?
        16'h0f38 : r.p0[1:0] == 2'h3 ? 16'h0f3a : 16'h0000;
    end
    e.ud_fault = !e.accept;
    return e;
  endfunction
  task automatic chk(logic [95:0] got, logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic dec(vec_gate_pkg::dec_req_t r);
    vec_gate_pkg::dec_resp_t e;
    vec_gate_pkg::dec_resp_t g;
    e = exp_resp(r, se);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req.valid <= 1'b0;
    #1 g = resp;
    chk(resp_valid, 1'b1);
    // Fields are only defined for accepted requests
    if (e.accept) chk(g, e);
    else chk({g.accept, g.ud_fault}, {e.accept, e.ud_fault});
  endtask
  task automatic rand_dec;
    vec_gate_pkg::dec_req_t r;
    logic [31:0] a;
    rng = xs(rng);
    a = rng;
    rng = xs(rng);
    r = {a, rng[14:0]};
    r.valid = 1'b1;
    r.group = vec_gate_pkg::grp_t'(3'(r.group % 3'h6));
    r.is_t1w_prefetch &= r.disp8[0] & r.p0[3];
    dec(r);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(8'h00, 32'h5003_0000);
    rd_reg(8'h04, 32'h0);
    rd_reg(8'h08, 32'h0);
    rd_reg(8'h0c, 32'h0);
    rd_reg(8'h10, 32'h0);
    rd_reg(8'h14, 32'h0);
    wr_reg(8'h00, 32'hffff_ffff);
    rd_reg(8'h00, 32'h5003_0000);
    wr_reg(8'h08, 32'hff);
    rd_reg(8'h10, 32'h1);
    wr_reg(8'h10, 32'h1);
    rd_reg(8'h10, 32'h0);
    wr_reg(8'h0c, 32'h3);
    rd_reg(8'h04, 32'h0800_0000);
    rd_reg(8'h08, 32'h1);
    foreach (ses[i]) begin
      wr_reg(8'h08, ses[i]);
      se = ses[i];
      rd_reg(8'h08, se);
      rd_reg(8'h10, 32'(exp_us(se, 1'b1)) << 8);
      chk(usable, exp_us(se, 1'b1));
    end
    wr_reg(8'h0c, 32'h2);
    rd_reg(8'h10, 32'h0);
    wr_reg(8'h0c, 32'h3);
    foreach (cfgs[i]) begin
      wr_reg(8'h08, cfgs[i]);
      se = cfgs[i];
      hr = '0;
      hr.valid = 1'b1;
      hr.is_vec256 = 1'b1;
      dec(hr);
      repeat (150) rand_dec;
    end
    print_verdict;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
